// ---- pkg/aasu_pkg.sv ----
// Shared constants, types and helpers of the accumulator add/subtract unit.
package aasu_pkg;

  // ==========================================================================
  // Timing: clock states per machine cycle, one clock state per CLK_SYS cycle.
  // ==========================================================================
  localparam logic [2:0] T_FIRST   = 3'h1;  // First clock state of a machine cycle.
  localparam logic [2:0] T_SECOND  = 3'h2;  // Clock state after an opcode is taken.
  localparam logic [2:0] T_OPCODE  = 3'h4;  // Opcode fetch machine cycle length.
  localparam logic [2:0] T_OPERAND = 3'h3;  // Operand or displacement byte read.
  localparam logic [2:0] T_CALC    = 3'h5;  // Index address calculation cycle.
  localparam logic [2:0] T_MEMRD   = 3'h3;  // Memory operand read cycle.

  // ==========================================================================
  // Opcode fields.
  // ==========================================================================
  localparam logic [7:0] OPC_PFX_FIRST  = 8'hdd;  // Selects first_index_pair.
  localparam logic [7:0] OPC_PFX_SECOND = 8'hfd;  // Selects second_index_pair.
  localparam logic [1:0] GRP_ARITH      = 2'h2;   // Register and memory forms.
  localparam logic [1:0] GRP_IMM        = 2'h3;   // Immediate forms.
  localparam logic [2:0] SEL_H          = 3'h4;   // High byte of the pointer pair.
  localparam logic [2:0] SEL_L          = 3'h5;   // Low byte of the pointer pair.
  localparam logic [2:0] SEL_MEM        = 3'h6;   // Memory or immediate operand.
  localparam logic [2:0] SEL_ACC        = 3'h7;   // Accumulator as operand.

  // ==========================================================================
  // Flag bit positions and reset values.
  // ==========================================================================
  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_OPC  = 5'b00010,
    S_BYTE = 5'b00100,
    S_CALC = 5'b01000,
    S_MEM  = 5'b10000
  } aasu_state_t;

  // True for add, add-with-carry, subtract and subtract-with-carry opcodes.
  function automatic logic aasu_is_arith(input logic [7:0] opc);
    return (opc[5] == 1'b0) &&
           ((opc[7:6] == GRP_ARITH) || ((opc[7:6] == GRP_IMM) && (opc[2:0] == SEL_MEM)));
  endfunction

  // Index pair plus a two's complement displacement, wrapping at 64K.
  function automatic logic [15:0] aasu_index_addr(input logic [15:0] base,
                                                  input logic [7:0]  disp);
    return base + {{8{disp[7]}}, disp};
  endfunction

endpackage

// ---- pkg/aasu_alu_if.sv ----
// Operand and result bundle between the sequencer and the adder.
`timescale 1ns/1ps
`default_nettype none
interface aasu_alu_if;
  logic [7:0] a;      // Accumulator operand.
  logic [7:0] b;      // Second operand.
  logic       cin;    // Carry or borrow in.
  logic       sub;    // High for subtraction.
  logic [7:0] res;    // Result byte.
  logic [7:0] flags;  // Flags produced by the operation.
  modport core (output a, b, cin, sub, input res, flags);
  modport alu  (input a, b, cin, sub, output res, flags);
endinterface
`default_nettype wire

// ---- logic/aasu_alu.sv ----
// Combinational 8-bit adder/subtractor with flag generation.
`timescale 1ns/1ps
`default_nettype none
module aasu_alu
  import aasu_pkg::*;
(
  aasu_alu_if.alu bus
);

  // ==========================================================================
  // Arithmetic and flags.
  // ==========================================================================
  logic [8:0] full;  // Nine-bit sum or difference; bit 8 is carry or borrow.
  logic [4:0] low;   // Low nibble result; bit 4 is half carry or borrow.
  logic       ovf;   // Signed overflow.

  // Separate add and subtract paths share one flag assembly; only overflow differs.
  always_comb begin
    if (bus.sub) begin
      full = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin};
      low  = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, bus.cin};
      ovf  = (bus.a[7] != bus.b[7]) && (full[7] != bus.a[7]);
    end else begin
      full = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
      low  = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
      ovf  = (bus.a[7] == bus.b[7]) && (full[7] != bus.a[7]);
    end
    bus.res            = full[7:0];
    bus.flags          = 8'h00;
    bus.flags[FLAG_S]  = full[7];
    bus.flags[FLAG_Z]  = (full[7:0] == 8'h00);
    bus.flags[FLAG_H]  = low[4];
    bus.flags[FLAG_PV] = ovf;
    bus.flags[FLAG_N]  = bus.sub;
    bus.flags[FLAG_C]  = full[8];
  end

endmodule // aasu_alu
`default_nettype wire

// ---- logic/aasu_regfile.sv ----
// Six general byte registers with registered read and the pointer pair output.
`timescale 1ns/1ps
`default_nettype none
module aasu_regfile
  import aasu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_sel,
  input  wire logic [7:0]  wr_data,
  input  wire logic [2:0]  rd_sel,
  output var  logic [7:0]  rd_data,
  output var  logic [15:0] ptr
);

  // ==========================================================================
  // Storage.
  // ==========================================================================
  logic [7:0] regs      [0:5];  // Held bytes, indexed by select code.
  logic [7:0] next_regs [0:5];  // Next values.
  logic [7:0] next_rd;          // Next read data.

  // Codes for the memory operand and the accumulator hold nothing here.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      next_regs[i] = regs[i];
      if (wr_en && (wr_sel == 3'(i))) begin
        next_regs[i] = wr_data;
      end
    end
    next_rd = (rd_sel < SEL_MEM) ? regs[rd_sel] : 8'h00;
  end

  // Registered read costs a cycle, which the four-state fetch easily hides.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 6; i++) begin
        regs[i] <= BYTE_RST;
      end
      rd_data <= BYTE_RST;
    end else begin
      regs    <= next_regs;
      rd_data <= next_rd;
    end
  end

  assign ptr = {regs[SEL_H], regs[SEL_L]};

endmodule // aasu_regfile
`default_nettype wire

// ---- logic/aasu_top.sv ----
// Accumulator add/subtract unit: opcode sequencing, operand fetch and flags.
`timescale 1ns/1ps
`default_nettype none
module aasu_top
  import aasu_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        FETCH_VALID,
  input  wire logic [7:0]  FETCH_BYTE,
  output var  logic        FETCH_READY,
  output var  logic        MEM_RD_REQ,
  output var  logic [15:0] MEM_ADDR,
  input  wire logic        MEM_RD_VALID,
  input  wire logic [7:0]  MEM_RD_DATA,
  input  wire logic [15:0] FIRST_INDEX_PAIR,
  input  wire logic [15:0] SECOND_INDEX_PAIR,
  input  wire logic        REG_WR_EN,
  input  wire logic [2:0]  REG_WR_SEL,
  input  wire logic [7:0]  REG_WR_DATA,
  input  wire logic        ACC_WR_EN,
  input  wire logic [7:0]  ACC_WR_DATA,
  input  wire logic        FLAG_WR_EN,
  input  wire logic [7:0]  FLAG_WR_DATA,
  output var  logic [7:0]  ACC,
  output var  logic [7:0]  FLAGS,
  output var  logic        BUSY,
  output var  logic        INSN_DONE,
  output var  logic        INSN_UNSUPPORTED
);

  // ==========================================================================
  // State and decode.
  // ==========================================================================
  aasu_state_t state, next_state;        // Machine cycle in progress.
  logic [2:0]  tcnt, next_tcnt;          // Clock state within the cycle.
  logic [7:0]  opc, next_opc;            // Latched opcode.
  logic [7:0]  byte_reg, next_byte_reg;  // Immediate, displacement or memory byte.
  logic        idx_on, next_idx_on;      // An index prefix is pending.
  logic        idx_second, next_idx_second;  // Prefix chose the second pair.
  logic [15:0] next_mem_addr;            // Operand address.
  logic [7:0]  next_acc;                 // Next accumulator.
  logic [7:0]  next_flags;               // Next flags.
  logic [7:0]  rf_rd;                    // Registered register read data.
  logic [15:0] ptr;                      // memory_pointer_pair.
  logic        take;                     // Opcode byte accepted this cycle.
  logic        opc_end;                  // Last state of an opcode fetch.
  logic        reg_form;                 // Opcode names a register operand.
  logic        mem_form;                 // Opcode names a memory operand.
  logic        wb;                       // Arithmetic writeback this cycle.
  logic        unsup;                    // Instruction abandoned this cycle.

  aasu_alu_if alu_if ();

  aasu_alu u_alu (
    .bus (alu_if.alu)
  );

  aasu_regfile u_regfile (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .wr_en   (REG_WR_EN),
    .wr_sel  (REG_WR_SEL),
    .wr_data (REG_WR_DATA),
    .rd_sel  (opc[2:0]),
    .rd_data (rf_rd),
    .ptr     (ptr)
  );

  // Decode of the latched opcode; bits 5:3 give the operation.
  always_comb begin
    reg_form = (opc[7:6] == GRP_ARITH) && (opc[2:0] != SEL_MEM);
    mem_form = (opc[7:6] == GRP_ARITH) && (opc[2:0] == SEL_MEM);
    take     = (state == S_IDLE) && FETCH_VALID;
    opc_end  = (state == S_OPC) && (tcnt == T_OPCODE);
  end

  // ==========================================================================
  // Operands into the adder.
  // ==========================================================================
  // Carry in only for the with-carry variants; opcode bit 4 selects subtract.
  always_comb begin
    alu_if.a   = ACC;
    alu_if.sub = opc[4];
    alu_if.cin = opc[3] & FLAGS[FLAG_C];
    if (reg_form) begin
      alu_if.b = (opc[2:0] == SEL_ACC) ? ACC : rf_rd;
    end else begin
      alu_if.b = byte_reg;
    end
  end

  // ==========================================================================
  // Sequencer.
  // ==========================================================================
  // Handshake outputs are combinational: the byte is taken on the same edge.
  always_comb begin
    FETCH_READY = (state == S_IDLE) || ((state == S_BYTE) && (tcnt == T_FIRST));
    MEM_RD_REQ  = (state == S_MEM) && (tcnt == T_FIRST);
    BUSY        = (state != S_IDLE) || idx_on;
  end

  // Each machine cycle counts its clock states; the first state of an operand
  // or memory read stretches into wait states until the byte arrives.
  always_comb begin
    next_state      = state;
    next_tcnt       = tcnt + 3'h1;
    next_opc        = opc;
    next_byte_reg   = byte_reg;
    next_idx_on     = idx_on;
    next_idx_second = idx_second;
    next_mem_addr   = MEM_ADDR;
    wb              = 1'b0;
    unsup           = 1'b0;
    case (state)
      S_IDLE: begin
        next_tcnt = T_SECOND;
        if (take) begin
          next_opc   = FETCH_BYTE;
          next_state = S_OPC;
        end
      end
      S_OPC: begin
        if (opc_end) begin
          next_tcnt  = T_FIRST;
          next_state = S_IDLE;
          if ((opc == OPC_PFX_FIRST) || (opc == OPC_PFX_SECOND)) begin
            // A repeated prefix simply replaces the earlier one.
            next_idx_on     = 1'b1;
            next_idx_second = (opc == OPC_PFX_SECOND);
          end else if (aasu_is_arith(opc) && reg_form && !idx_on) begin
            wb = 1'b1;
          end else if (aasu_is_arith(opc) && !mem_form && !idx_on) begin
            next_state = S_BYTE;
          end else if (aasu_is_arith(opc) && mem_form && idx_on) begin
            next_state = S_BYTE;
          end else if (aasu_is_arith(opc) && mem_form) begin
            next_mem_addr = ptr;
            next_state    = S_MEM;
          end else begin
            // Other operations belong to other units; report and drop.
            unsup       = 1'b1;
            next_idx_on = 1'b0;
          end
        end
      end
      S_BYTE: begin
        if ((tcnt == T_FIRST) && !FETCH_VALID) begin
          next_tcnt = T_FIRST;
        end else if (tcnt == T_FIRST) begin
          next_byte_reg = FETCH_BYTE;
        end else if (tcnt == T_OPERAND) begin
          next_tcnt = T_FIRST;
          if (idx_on) begin
            next_state = S_CALC;
          end else begin
            wb         = 1'b1;
            next_state = S_IDLE;
          end
        end
      end
      S_CALC: begin
        if (tcnt == T_CALC) begin
          next_tcnt     = T_FIRST;
          next_state    = S_MEM;
          next_mem_addr = aasu_index_addr(idx_second ? SECOND_INDEX_PAIR
                                                     : FIRST_INDEX_PAIR, byte_reg);
        end
      end
      S_MEM: begin
        if ((tcnt == T_FIRST) && !MEM_RD_VALID) begin
          next_tcnt = T_FIRST;
        end else if (tcnt == T_FIRST) begin
          next_byte_reg = MEM_RD_DATA;
        end else if (tcnt == T_MEMRD) begin
          next_tcnt   = T_FIRST;
          wb          = 1'b1;
          next_idx_on = 1'b0;
          next_state  = S_IDLE;
        end
      end
      default: begin
        next_state  = S_IDLE;
        next_tcnt   = T_FIRST;
        next_idx_on = 1'b0;
      end
    endcase
    INSN_DONE        = wb || unsup;
    INSN_UNSUPPORTED = unsup;
  end

  // Writeback wins over a software load in the same cycle.
  always_comb begin
    next_acc   = ACC_WR_EN ? ACC_WR_DATA : ACC;
    next_flags = FLAG_WR_EN ? FLAG_WR_DATA : FLAGS;
    if (wb) begin
      next_acc   = alu_if.res;
      next_flags = alu_if.flags;
    end
  end

  // Sequencer and result registers.
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state      <= S_IDLE;
      tcnt       <= T_FIRST;
      opc        <= BYTE_RST;
      byte_reg   <= BYTE_RST;
      idx_on     <= 1'b0;
      idx_second <= 1'b0;
      MEM_ADDR   <= ADDR_RST;
      ACC        <= ACC_RST;
      FLAGS      <= FLAGS_RST;
    end else begin
      state      <= next_state;
      tcnt       <= next_tcnt;
      opc        <= next_opc;
      byte_reg   <= next_byte_reg;
      idx_on     <= next_idx_on;
      idx_second <= next_idx_second;
      MEM_ADDR   <= next_mem_addr;
      ACC        <= next_acc;
      FLAGS      <= next_flags;
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  property p_reg_timing;
    take && aasu_is_arith(FETCH_BYTE) && (FETCH_BYTE[7:6] == GRP_ARITH) &&
    (FETCH_BYTE[2:0] != SEL_MEM) && !idx_on |-> !INSN_DONE [*3] ##1 INSN_DONE;
  endproperty
  a_reg_timing: assert property (p_reg_timing) else $error("register add not 4 states");

  property p_acc_select;
    (state == S_OPC) && reg_form && (opc[2:0] == SEL_ACC) |-> alu_if.b == ACC;
  endproperty
  a_acc_select: assert property (p_acc_select) else $error("code 111 not accumulator");

  property p_imm_timing;
    (take && (FETCH_BYTE == 8'hc6) && !idx_on) ##4 FETCH_VALID |-> ##2 wb;
  endproperty
  a_imm_timing: assert property (p_imm_timing) else $error("immediate add not 7 states");

  property p_ptr_read;
    (take && (FETCH_BYTE == 8'h86) && !idx_on) |-> ##4 (MEM_RD_REQ && (MEM_ADDR == $past(ptr)));
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer read misplaced");

  property p_calc_len;
    $rose(state == S_CALC) |-> (state == S_CALC) [*5] ##1 MEM_RD_REQ;
  endproperty
  a_calc_len: assert property (p_calc_len) else $error("address cycle not 5 states");

  property p_idx_addr;
    (state == S_CALC) && (tcnt == T_CALC) |=> MEM_ADDR == aasu_index_addr(
      $past(idx_second) ? $past(SECOND_INDEX_PAIR) : $past(FIRST_INDEX_PAIR), $past(byte_reg));
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("index address wrong");

  property p_sign_zero;
    wb |=> (FLAGS[FLAG_S] == ACC[7]) && (FLAGS[FLAG_Z] == (ACC == 8'h00));
  endproperty
  a_sign_zero: assert property (p_sign_zero) else $error("sign or zero flag wrong");

  property p_half;
    wb |=> FLAGS[FLAG_H] == ($past(alu_if.a[4]) ^ $past(alu_if.b[4]) ^ ACC[4]);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_add_ovf;
    wb && !alu_if.sub |=> FLAGS[FLAG_PV] ==
      (($past(alu_if.a[7]) == $past(alu_if.b[7])) && (ACC[7] != $past(alu_if.a[7])));
  endproperty
  a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong");

  property p_add_n;
    wb && !alu_if.sub |=> !FLAGS[FLAG_N];
  endproperty
  a_add_n: assert property (p_add_n) else $error("add left N set");

  property p_add_carry;
    wb && !alu_if.sub |=> FLAGS[FLAG_C] == (({1'b0, $past(alu_if.a)} +
      {1'b0, $past(alu_if.b)} + {8'h00, $past(alu_if.cin)}) > 9'h0ff);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

  property p_adc_sum;
    wb && (opc[5:3] == 3'h1) |=> ACC == ($past(alu_if.a) + $past(alu_if.b) + $past(FLAGS[FLAG_C]));
  endproperty
  a_adc_sum: assert property (p_adc_sum) else $error("carry not added");

  property p_sub_res;
    wb && (opc[5:3] == 3'h2) |=> (ACC == ($past(alu_if.a) - $past(alu_if.b))) && FLAGS[FLAG_N];
  endproperty
  a_sub_res: assert property (p_sub_res) else $error("subtract wrong");

  property p_sub_ovf;
    wb && alu_if.sub |=> FLAGS[FLAG_PV] ==
      (($past(alu_if.a[7]) != $past(alu_if.b[7])) && (ACC[7] != $past(alu_if.a[7])));
  endproperty
  a_sub_ovf: assert property (p_sub_ovf) else $error("subtract overflow wrong");

  c_reg_add: cover property (take && (FETCH_BYTE == 8'h80) ##3 wb);
  c_imm_add: cover property (take && (FETCH_BYTE == 8'hc6) ##6 wb);
  c_second_idx: cover property (idx_second && wb && (opc[5:3] == 3'h1));
  c_sub_borrow: cover property (wb && alu_if.sub ##1 FLAGS[FLAG_C]);

endmodule // aasu_top
`default_nettype wire

// ---- test/aasu_mem_model.sv ----
// Behavioural memory read path that answers the unit's operand reads.
`timescale 1ns/1ps
`default_nettype none
module aasu_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wait_n,
  output var  logic        valid,
  output var  logic [7:0]  data
);
  int         cnt  = 0;      // Wait states served so far.
  logic [7:0] last = 8'h00;  // Last byte handed over.
  initial valid = 1'b0;
  initial data  = 8'h00;
  // ==========================================================================
  // Read answer
  // ==========================================================================
  // The byte is a fixed mix of the address, so a wrong address shows up
  // as a wrong sum. Outside a transfer the lines carry the inverse of the
  // last byte, so a late sample by the unit cannot pass by chance.
  always @(posedge clk) begin
    #1;
    if (rst || !req || valid) begin
      valid = 1'b0;
      cnt   = 0;
    end else if (cnt >= wait_n) begin
      valid = 1'b1;
      last  = addr[7:0] ^ addr[15:8] ^ 8'h5a;
    end else begin
      cnt++;
    end
    data = valid ? last : ~last;
  end
endmodule  // aasu_mem_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking testbench of the accumulator add/subtract unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import aasu_pkg::*;
;
  logic        clk = 1'b0;     // 40 MHz system clock.
  logic        rst = 1'b1;     // Reset, held at the start.
  logic        fv  = 1'b0;     // Instruction byte valid.
  logic [7:0]  fb  = 8'h00;    // Instruction byte.
  logic        rwe = 1'b0;     // Register load strobe and its fields.
  logic [2:0]  rws = 3'h0;
  logic [7:0]  rwd = 8'h00;
  logic        awe = 1'b0;     // Accumulator and flag loads.
  logic [7:0]  awd = 8'h00;
  logic        fwe = 1'b0;
  logic [7:0]  fwd = 8'h00;
  logic [15:0] ipa = 16'h1000; // Index pairs.
  logic [15:0] ipb = 16'h2ff0;
  logic        rdy, mreq, mval, busy, done, uns;
  logic [15:0] maddr;
  logic [7:0]  mdat, acc, flg, ef;
  logic [7:0]  rg [0:7];       // Bench copy: B..L, slot 7 is the accumulator.
  logic [7:0]  iv [0:5] = '{8'h11, 8'h7f, 8'h80, 8'h0f, 8'h23, 8'h25};
  logic [7:0]  dv [0:3] = '{8'h05, 8'h80, 8'hff, 8'h7f};
  int          error_cnt = 0;
  int          compares  = 0;
  int          cyc       = 0;  // Rising edges seen.
  int          mem_wait  = 0;  // Wait states the memory adds.
  // ==========================================================================
  // Clock, partner and unit
  // ==========================================================================
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  aasu_mem_model u_aasu_mem_model (.clk(clk), .rst(rst), .req(mreq), .addr(maddr),
    .wait_n(32'(mem_wait)), .valid(mval), .data(mdat));
  aasu_top u_aasu_top (.CLK_SYS(clk), .SYS_RST(rst), .FETCH_VALID(fv), .FETCH_BYTE(fb),
    .FETCH_READY(rdy), .MEM_RD_REQ(mreq), .MEM_ADDR(maddr), .MEM_RD_VALID(mval),
    .MEM_RD_DATA(mdat), .FIRST_INDEX_PAIR(ipa), .SECOND_INDEX_PAIR(ipb), .REG_WR_EN(rwe),
    .REG_WR_SEL(rws), .REG_WR_DATA(rwd), .ACC_WR_EN(awe), .ACC_WR_DATA(awd),
    .FLAG_WR_EN(fwe), .FLAG_WR_DATA(fwd), .ACC(acc), .FLAGS(flg), .BUSY(busy),
    .INSN_DONE(done), .INSN_UNSUPPORTED(uns));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Compare and count; a mismatch prints one line.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Reference arithmetic: op bit 1 selects subtract, bit 0 adds the carry in.
  function automatic logic [7:0] calc(input logic [1:0] op, input logic [7:0] a, b,
                                      inout logic [7:0] f);
    logic [8:0] r;
    logic       c, h, v;
    c = op[0] & f[FLAG_C];
    if (op[1]) begin
      r = {1'b0, a} - {1'b0, b} - 9'(c);
      h = {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(c);
      v = (a[7] != b[7]) && (r[7] != a[7]);
    end else begin
      r = {1'b0, a} + {1'b0, b} + 9'(c);
      h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c)) > 5'h0f;
      v = (a[7] == b[7]) && (r[7] != a[7]);
    end
    f = {r[7], r[7:0] == 8'h00, 1'b0, h, 1'b0, v, op[1], r[8]};
    return r[7:0];
  endfunction
  // Offer one byte and hold it until an edge with ready high takes it.
  task automatic put(input logic [7:0] b, output int tk);
    logic ok;
    fv = 1'b1;
    fb = b;
    do begin
      ok = rdy;
      tk = cyc;
      @(posedge clk);
      #1;
    end while (ok !== 1'b1);
  endtask
  // Run one instruction; check its length in states, the refusal flag and
  // the accumulator and flags in the cycle after the done pulse.
  task automatic insn(input logic [7:0] pfx, opc, arg, input int n_st);
    logic [7:0]  b;
    logic [15:0] ad;
    logic        ar;
    int          tk, tj, n;
    ar = !opc[5] && (opc[7:6] == 2'h2 || (opc[7:6] == 2'h3 && opc[2:0] == 3'h6));
    ad = (pfx == 8'h00) ? {rg[4], rg[5]} : (pfx == 8'hdd ? ipa : ipb) + {{8{arg[7]}}, arg};
    b  = (opc[2:0] != 3'h6) ? rg[opc[2:0]] : opc[6] ? arg : ad[7:0] ^ ad[15:8] ^ 8'h5a;
    if (pfx != 8'h00) put(pfx, tk);
    put(opc, tj);
    if (pfx == 8'h00) tk = tj;
    if (opc[7:6] == 2'h3 || pfx != 8'h00) put(arg, tj);
    fv = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("states", 16'(n_st), 16'(cyc - tk + 1));
    chk("unsupported", {15'h0, !ar}, {15'h0, uns});
    if (ar) rg[7] = calc(opc[4:3], rg[7], b, ef);
    @(posedge clk);
    #1;
    chk("acc", {8'h00, rg[7]}, {8'h00, acc});
    chk("flags", {8'h00, ef}, {8'h00, flg});
  endtask
  // Verdict and end of run.
  task automatic final_report();
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk("acc_rst", {8'h00, ACC_RST}, {8'h00, acc});
    chk("flags_rst", {8'h00, FLAGS_RST}, {8'h00, flg});
    chk("addr_rst", ADDR_RST, maddr);
    chk("ready_busy_rst", 16'h0001, {14'h0, busy, rdy});
    rst = 1'b0;
    // Load B..L, then the accumulator and all flags set, so the first ADD must ignore a carry.
    for (int i = 0; i < 6; i++) begin
      rwe = 1'b1;
      rws = 3'(i);
      rwd = iv[i];
      rg[i] = iv[i];
      @(posedge clk);
      #1;
    end
    rwe = 1'b0;
    awe = 1'b1;
    awd = 8'h44;
    fwe = 1'b1;
    fwd = 8'hff;
    rg[7] = 8'h44;
    ef = 8'hff;
    @(posedge clk);
    #1;
    awe = 1'b0;
    fwe = 1'b0;
    @(posedge clk);
    #1;
    chk("acc_load", 16'h0044, {8'h00, acc});
    // Every operation on every register, back to back; SUB A gives zero.
    for (int op = 0; op < 4; op++) begin
      for (int s = 0; s < 8; s++) begin
        if (s != 6) insn(8'h00, {2'h2, 3'(op), 3'(s)}, 8'h00, 4);
      end
      insn(8'h00, {2'h3, 3'(op), 3'h6}, dv[op] ^ 8'h9c, 7);
      insn(8'h00, {2'h2, 3'(op), 3'h6}, 8'h00, 7);
      insn(OPC_PFX_FIRST, {2'h2, 3'(op), 3'h6}, dv[op], 19);
      insn(OPC_PFX_SECOND, {2'h2, 3'(op), 3'h6}, dv[3 - op], 19);
    end
    // A slow memory stretches the read state by its wait states.
    mem_wait = 2;
    insn(8'h00, 8'h86, 8'h00, 9);
    // A logic opcode is refused and leaves accumulator and flags alone.
    insn(8'h00, 8'ha0, 8'h00, 4);
    final_report();
  end
  // Cut a hang short well after the tests should have ended.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule  // tb_top
`default_nettype wire
